// >>> hw/mfp_config.sv
`timescale 1ns/1ns
`include "mfp_map.svh"

// What this block does
// R1 - Holds the 8-bit pin configuration register at address 20h, loaded from non-volatile memory.
// R2 - With bit 7 set, supply arrival powers the device up to ACTIVE even if the enable pin says off.
// R3 - With bit 6 set, the fault retry counter is masked during first power-up until ACTIVE.
// R4 - Bits 5-4 pick push-button (0), level enable (1 or 3) or voltage sense (2).
// R5 - Bit 3 picks short (120us / 200ms) or long (50ms / 600ms) enable-pin filtering.
// R6 - The host changes the filter-length bit only in the initialize state.
// R7 - The host leaves the enable-pin function alone after memory load unless staging a program.
// R8 - Bit 2 set makes the output pin the active-low wake request.
// R9 - Bits 1-0 pick mode only (0 or 3), standby only (1) or mode plus standby (2).
// R10 - Bit 2 clear makes the output pin a plain output following the output-state bit.
module mfp_config #(
    parameter logic [`MFP_CNT_W-1:0] PB_SHORT_CYC = `MFP_CNT_W'(`MFP_PB_SHORT_CYC),
    parameter logic [`MFP_CNT_W-1:0] EN_LONG_CYC = `MFP_CNT_W'(`MFP_EN_LONG_CYC),
    parameter logic [`MFP_CNT_W-1:0] PB_LONG_CYC = `MFP_CNT_W'(`MFP_PB_LONG_CYC)
) (
    input wire logic sys_clk_i, // 25 MHz clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic [`MFP_ADDR_W-1:0] reg_addr_i, // Register address from I2C core
    input wire logic reg_wr_i, // Write strobe, one cycle
    input wire logic [7:0] reg_wdata_i, // Write data
    output logic [7:0] reg_rdata_o, // Read data, one cycle after address
    input wire logic nvm_load_i, // Default load strobe, one cycle
    input wire logic [7:0] nvm_data_i, // Default value from memory
    input wire logic system_supply_i, // Supply present, pin
    input wire logic enable_pin_i, // Enable / push-button / sense pin
    input wire logic mode_pin_i, // Mode / standby pin
    input wire logic active_state_i, // Sequencer is in ACTIVE
    input wire logic general_output_i, // Output-state bit
    input wire logic wake_req_i, // Wake request from sequencer
    output logic power_up_req_o, // Request to sequence up
    output logic retry_mask_o, // Ignore fault retry counter
    output logic enable_filtered_o, // Filtered enable pin level
    output logic out_pin_o, // Output / wake pin level
    output logic mode_ctrl_o, // Converter mode from pin
    output logic standby_request_o // Standby request from pin
);
    mfp_pkg::mfp_cfg_t cfg_reg;
    mfp_pkg::mfp_en_fn_t en_fn;
    mfp_pkg::mfp_mode_role_t mode_role;
    logic [2:0] sup_sync_reg;
    logic [1:0] en_sync_reg, mode_sync_reg;
    logic [`MFP_CNT_W-1:0] filt_cnt_reg, filt_len;
    logic filt_reg, first_pu_reg, fsd_hold_reg, pb_on_reg;
    logic supply_rise, filt_flip, sel_hit, pb_press;

    // Address decode; the register is the only thing at this slave
    assign sel_hit = (reg_addr_i == `MFP_CFG2_ADDR);

    // Memory load wins over a host write in the same cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_reg <= `MFP_CFG2_RESET;
        end else if (nvm_load_i) begin
            cfg_reg <= nvm_data_i; // R1
        end else if (reg_wr_i && sel_hit) begin
            cfg_reg <= reg_wdata_i; // R1
        end
    end

    // Registered read; unmapped addresses read zero
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= sel_hit ? cfg_reg : 8'h00; // R1
        end
    end

    // Pins come from outside; two flops, third flop only for edge finding
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sup_sync_reg <= 3'h0;
            en_sync_reg <= 2'h0;
            mode_sync_reg <= 2'h0;
        end else begin
            sup_sync_reg <= {sup_sync_reg[1:0], system_supply_i};
            en_sync_reg <= {en_sync_reg[0], enable_pin_i};
            mode_sync_reg <= {mode_sync_reg[0], mode_pin_i};
        end
    end
    assign supply_rise = sup_sync_reg[1] && !sup_sync_reg[2];

    // Function decode; 3 aliases level enable
    assign en_fn = (cfg_reg.en_func == `MFP_EN_PB) ? mfp_pkg::MFP_FN_PUSH_BUTTON : // R4
                   (cfg_reg.en_func == `MFP_EN_VOLTAGE_SENSE_INPUT) ? mfp_pkg::MFP_FN_VOLTAGE_SENSE :
                   mfp_pkg::MFP_FN_LEVEL_ENABLE;

    // Filter length from function and length bit
    assign filt_len = (en_fn == mfp_pkg::MFP_FN_PUSH_BUTTON) ?
                      (cfg_reg.filt_long ? PB_LONG_CYC : PB_SHORT_CYC) : // R5
                      (cfg_reg.filt_long ? EN_LONG_CYC : `MFP_CNT_W'(`MFP_EN_SHORT_CYC));
    assign filt_flip = (en_sync_reg[1] != filt_reg) && (filt_cnt_reg >= filt_len - 1'b1);

    // Pin must hold its new level for the full length before the filter follows;
    // a length change mid-count may shorten one filter period, hence initialize-only writes
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            filt_cnt_reg <= '0;
            filt_reg <= 1'b0;
        end else if (en_sync_reg[1] == filt_reg || filt_flip) begin
            filt_cnt_reg <= '0;
            filt_reg <= filt_flip ? en_sync_reg[1] : filt_reg; // R5
        end else begin
            filt_cnt_reg <= filt_cnt_reg + 1'b1; // R5
        end
    end
    assign pb_press = filt_flip && !en_sync_reg[1];

    // Push-button press (pin low) toggles the on request
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pb_on_reg <= 1'b0;
        end else if (en_fn != mfp_pkg::MFP_FN_PUSH_BUTTON) begin
            pb_on_reg <= 1'b0;
        end else if (pb_press) begin
            pb_on_reg <= !pb_on_reg; // R4
        end
    end

    // First-supply power-up holds until ACTIVE, overriding an off level
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fsd_hold_reg <= 1'b0;
            first_pu_reg <= 1'b1;
        end else begin
            if (supply_rise && cfg_reg.pu_first) begin
                fsd_hold_reg <= 1'b1; // R2
            end else if (active_state_i) begin
                fsd_hold_reg <= 1'b0;
            end
            if (active_state_i) begin
                first_pu_reg <= 1'b0; // R3
            end
        end
    end

    // Output stage, all from flops
    assign mode_role.mode_ctrl = (cfg_reg.mode_func != `MFP_MODE_STANDBY_REQUEST); // R9
    assign mode_role.standby_ctrl = (cfg_reg.mode_func == `MFP_MODE_STANDBY_REQUEST) ||
                                    (cfg_reg.mode_func == `MFP_MODE_BOTH); // R9
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_up_req_o <= 1'b0;
            retry_mask_o <= 1'b0;
            enable_filtered_o <= 1'b0;
            out_pin_o <= 1'b0;
            mode_ctrl_o <= 1'b0;
            standby_request_o <= 1'b0;
        end else begin
            power_up_req_o <= fsd_hold_reg || pb_on_reg ||
                              (en_fn != mfp_pkg::MFP_FN_PUSH_BUTTON && filt_reg); // R2 R4
            retry_mask_o <= cfg_reg.mask_retry && first_pu_reg && !active_state_i; // R3
            enable_filtered_o <= filt_reg;
            out_pin_o <= cfg_reg.out_func ? !wake_req_i : general_output_i; // R8 R10
            mode_ctrl_o <= mode_role.mode_ctrl && mode_sync_reg[1]; // R9
            standby_request_o <= mode_role.standby_ctrl && mode_sync_reg[1]; // R9
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_supply_up;
        supply_rise && cfg_reg.pu_first;
    endsequence
    sequence s_held_until_active;
        power_up_req_o [*2];
    endsequence

    a_reg_write_lands: assert property ( // R1
        reg_wr_i && sel_hit && !nvm_load_i |=> cfg_reg == $past(reg_wdata_i))
        else $error("host write not stored");
    a_nvm_load_lands: assert property ( // R1
        nvm_load_i |=> cfg_reg == $past(nvm_data_i))
        else $error("memory load not stored");
    a_read_back: assert property ( // R1
        ##1 $past(sel_hit) |-> reg_rdata_o == $past(cfg_reg))
        else $error("read data wrong");
    a_first_supply_up: assert property ( // R2
        s_supply_up ##1 !active_state_i |-> ##1 s_held_until_active)
        else $error("first supply power-up missing");
    a_retry_masked: assert property ( // R3
        ##1 $past(cfg_reg.mask_retry && first_pu_reg && !active_state_i) |-> retry_mask_o)
        else $error("retry counter not masked");
    a_retry_after_active: assert property ( // R3
        active_state_i |=> ##1 !retry_mask_o)
        else $error("retry mask held after active");
    a_level_follows: assert property ( // R4
        en_fn == mfp_pkg::MFP_FN_LEVEL_ENABLE && filt_reg |=> power_up_req_o)
        else $error("level enable ignored");
    a_filter_hold: assert property ( // R5
        filt_flip |-> filt_cnt_reg == filt_len - 1'b1)
        else $error("filter flipped at wrong count");
    a_wake_pin: assert property ( // R8
        cfg_reg.out_func && wake_req_i |=> !out_pin_o)
        else $error("wake output not driven low");
    a_gpo_pin: assert property ( // R10
        !cfg_reg.out_func |=> out_pin_o == $past(general_output_i))
        else $error("general output not followed");
    a_mode_roles: assert property ( // R9
        cfg_reg.mode_func == `MFP_MODE_STANDBY_REQUEST && $stable(cfg_reg) |=> !mode_ctrl_o)
        else $error("mode control active in standby-only role");
    // Mode-only role must never raise a standby request, whatever the pin does
    a_mode_only_role: assert property ( // R9
        cfg_reg.mode_func == `MFP_MODE_ONLY_A && $stable(cfg_reg) |=> !standby_request_o)
        else $error("standby requested in mode-only role");
    // Each filtered press flips the on request exactly once
    a_button_toggle: assert property ( // R4
        en_fn == mfp_pkg::MFP_FN_PUSH_BUTTON && pb_press |=> pb_on_reg != $past(pb_on_reg))
        else $error("button press did not toggle request");
endmodule

// >>> hw/mfp_map.svh
`ifndef MFP_MAP_SVH
`define MFP_MAP_SVH

// Register address and layout
`define MFP_ADDR_W 8
`define MFP_CFG2_ADDR 8'h20
`define MFP_CFG2_RESET 8'h00
`define MFP_BIT_PU_FIRST 7
`define MFP_BIT_MASK_RETRY 6
`define MFP_BIT_FILT_LONG 3
`define MFP_BIT_OUT_FUNC 2

// Field encodings
`define MFP_EN_PB 2'h0
`define MFP_EN_LEVEL_A 2'h1
`define MFP_EN_VOLTAGE_SENSE_INPUT 2'h2
`define MFP_MODE_ONLY_A 2'h0
`define MFP_MODE_STANDBY_REQUEST 2'h1
`define MFP_MODE_BOTH 2'h2

// Clock rate and filter times
`define MFP_CLK_MHZ 25
`define MFP_CLK_KHZ 25000
`define MFP_T_EN_SHORT_US 120
`define MFP_T_PB_SHORT_MS 200
`define MFP_T_EN_LONG_MS 50
`define MFP_T_PB_LONG_MS 600
`define MFP_EN_SHORT_CYC (`MFP_T_EN_SHORT_US * `MFP_CLK_MHZ)
`define MFP_PB_SHORT_CYC (`MFP_T_PB_SHORT_MS * `MFP_CLK_KHZ)
`define MFP_EN_LONG_CYC (`MFP_T_EN_LONG_MS * `MFP_CLK_KHZ)
`define MFP_PB_LONG_CYC (`MFP_T_PB_LONG_MS * `MFP_CLK_KHZ)
`define MFP_CNT_W 24

`endif

// >>> hw/mfp_pkg.sv
package mfp_pkg;
    // Register image, bit 7 first
    typedef struct packed {
        logic pu_first;
        logic mask_retry;
        logic [1:0] en_func;
        logic filt_long;
        logic out_func;
        logic [1:0] mode_func;
    } mfp_cfg_t;

    // Decoded enable-pin function
    typedef enum logic [1:0] {
        MFP_FN_PUSH_BUTTON,
        MFP_FN_LEVEL_ENABLE,
        MFP_FN_VOLTAGE_SENSE
    } mfp_en_fn_t;

    // Decoded mode/standby pin role
    typedef struct packed {
        logic mode_ctrl;
        logic standby_ctrl;
    } mfp_mode_role_t;
endpackage

// >>> test/mfp_seq_model.sv
`timescale 1ns/1ns

// Sequencer stand-in: reaches ACTIVE a fixed ramp after a power-up request
module mfp_seq_model #(
    parameter int RAMP = 8
) (
    input wire logic clk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic power_up_req_i, // Request from the block
    output logic active_state_o // ACTIVE reached
);
    int cnt;

    // Sticky once reached; this stand-in never powers back down
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 0;
            active_state_o <= 1'h0;
        end else if (power_up_req_i && cnt < RAMP) begin
            cnt <= cnt + 1;
        end else if (cnt == RAMP) begin
            active_state_o <= 1'h1;
        end
    end
endmodule

// >>> test/mfp_config_bench.sv
`timescale 1ns/1ns
`include "mfp_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module mfp_config_bench;
    localparam int PB_S = 20;
    localparam int EN_L = 30;
    localparam int PB_L = 40;
    logic sys_clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, nvm_data = 8'h00, rdata;
    logic wr_s = 1'h0, nvm_load = 1'h0, supply = 1'h0, en_pin = 1'h1, mode_pin = 1'h0;
    logic gen_out = 1'h0, wake = 1'h0, active, pu_req, rmask, en_filt, out_pin, mode_ctrl, standby_request;
    int mismatches = 0;
    int checks_done = 0;
    int i;
    // Every enable-pin function at the short filter length, push-button and level enable also at the long one, with the length each implies
    logic [7:0] cfg [6] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h30};
    int len [6] = '{PB_S, PB_L, `MFP_EN_SHORT_CYC, EN_L, `MFP_EN_SHORT_CYC, `MFP_EN_SHORT_CYC};

    always #20 sys_clk_i = ~sys_clk_i;

    mfp_config #(.PB_SHORT_CYC(24'(PB_S)), .EN_LONG_CYC(24'(EN_L)), .PB_LONG_CYC(24'(PB_L)))
    i_mfp_config (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wr_i(wr_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .nvm_load_i(nvm_load),
        .nvm_data_i(nvm_data), .system_supply_i(supply), .enable_pin_i(en_pin),
        .mode_pin_i(mode_pin), .active_state_i(active), .general_output_i(gen_out),
        .wake_req_i(wake), .power_up_req_o(pu_req), .retry_mask_o(rmask),
        .enable_filtered_o(en_filt), .out_pin_o(out_pin), .mode_ctrl_o(mode_ctrl),
        .standby_request_o(standby_request));

    mfp_seq_model i_mfp_seq_model (.clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .power_up_req_i(pu_req), .active_state_o(active));

    // Waits n edges, then lets that edge's updates land before anything is looked at
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'h1;
        @(posedge sys_clk_i);
        wr_s <= 1'h0;
    endtask

    // Read data is registered, so it is valid after the edge that samples the address
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr <= a;
        tick(1);
        `CHK(rdata, e)
    endtask

    task automatic load(input logic [7:0] d);
        @(posedge sys_clk_i);
        nvm_data <= d;
        nvm_load <= 1'h1;
        @(posedge sys_clk_i);
        nvm_load <= 1'h0;
    endtask

    task automatic stop_test;
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard, well past the longest expected run
    initial begin
        #3000000;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'h1;
        tick(1);
        rd(8'h20, 8'h00);
        // Memory load and a host write on the same edge: the load must win
        fork
            wr(8'h20, 8'hFF);
            load(8'hC0);
        join
        rd(8'h20, 8'hC0);
        wr(8'h21, 8'h3C);
        rd(8'h21, 8'h00);
        rd(8'h20, 8'hC0);
        `CHK(pu_req, 1'h0)
        @(posedge sys_clk_i);
        supply <= 1'h1;
        for (i = 0; i < 10 && pu_req !== 1'h1; i++) tick(1);
        `CHK(pu_req, 1'h1)
        `CHK(rmask, 1'h1)
        for (i = 0; i < 20 && active !== 1'h1; i++) tick(1);
        `CHK(active, 1'h1)
        tick(3);
        `CHK(rmask, 1'h0)
        wr(8'h20, 8'h40);
        tick(3);
        `CHK(rmask, 1'h0)
        @(posedge sys_clk_i);
        mode_pin <= 1'h1;
        for (i = 0; i < 4; i++) begin
            wr(8'h20, 8'(i));
            tick(4);
            `CHK(mode_ctrl, i != 1)
            `CHK(standby_request, i == 1 || i == 2)
        end
        // Output-state bit tracks the wake request, so only the pin polarity tells the two sources apart
        for (i = 0; i < 4; i++) begin
            if (i % 2 == 0) wr(8'h20, i < 2 ? 8'h04 : 8'h00);
            @(posedge sys_clk_i);
            wake <= i[0];
            gen_out <= i[0];
            tick(3);
            `CHK(out_pin, i < 2 ? ~i[0] : i[0])
        end
        // Function changes go through the memory load, as the host may change them only when staging a program
        for (i = 0; i < 6; i++) begin
            load(cfg[i]);
            @(posedge sys_clk_i);
            en_pin <= 1'h0;
            tick(len[i] + 10);
            @(posedge sys_clk_i);
            en_pin <= 1'h1;
            tick(len[i] - 10);
            `CHK(en_filt, 1'h0)
            tick(20);
            `CHK(en_filt, 1'h1)
            tick(3);
            if (cfg[i][5:4] != 2'h0) `CHK(pu_req, 1'h1)
        end
        stop_test();
    end
endmodule
